// ===== ssp_port.sv
/*
  SPI slave port: 16-bit framed command slave over sampled pins, with
  configuration, control and status registers.
  Assumes the serial clock is far slower than clk (8 MHz against 200 MHz),
  and fault conditions arrive on clk as levels or one-cycle events.
*/
//
// Behaviour
// - Serial input shifted in on each rising serial clock edge while selected.
// - Serial output changes on each falling serial clock edge.
// - Deselected: clock and input ignored, output released.
// - Count pulses per frame; other than 16 discards frame, flags error.
// - Undefined command or bad address flags error, not executed.
// - Select falling enables output, loads pending response.
// - Select rising releases output and executes the command.
// - Both words shifted most significant bit first, in step.
// - Response shifted out belongs to the previous frame's command.
// - Check command echoes low twelve bits, inverts 14..12, bit 15 zero.
// - Self-test clear: host only clears status bits; set: any value.
// - Self-test set freezes fault updates; host clears it afterwards.
// - Nonexistent bits read zero and ignore every write.
// - Healthy drivers report 0, faulted drivers report 1.
// - Line status bit 0 reports line overtemperature, resets zero.
// - Model/revision register read-only: model 7..5, revision 4..0.
// - Device sets and clears non-fault status bits itself.
// - Word is command 4 bits, address 4 bits, data 8 bits.
// - Command codes 0 to 7 as check, read/write cfg, status, control, check response.
// - SPI error reported in bit 3 of system status register.
`timescale 1ns/1ps
module ssp_port
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Serial pins
  input  wire logic       select_n,
  input  wire logic       sclk,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe,
  // Line conditioner conditions
  input  wire logic [3:0] peak_level,
  input  wire logic       positive_clamp_flag,
  input  wire logic       negative_clamp_flag,
  input  wire logic       kline_overtemp_flag,
  // Power supply and system conditions, bit 3 unused
  input  wire logic [7:0] sys_fault_cond,
  // Register views
  output logic            self_test_write_enable,
  output logic [7:0]      line_conditioner_fault_status,
  output logic [7:0]      sys_fault_status
);

  import ssp_pkg::*;

  ssp_port_s_t   q;
  ssp_port_s_t   d;
  logic [2:0]    pins_s;
  logic          sel_s;
  logic          sclk_s;
  logic          si_s;
  logic [7:0]    line_cond;
  logic [7:0]    sys_cond;
  logic [7:0]    model_revision_id;
  logic          self_test;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Select idles high so a reset does not fake a frame start
  ssp_sync #(
    .W       (3),
    .RST_VAL (3'h4)
  ) u_sync (
    .clk    (clk),
    .reset  (reset),
    .pins   ({select_n, sclk, serial_in}),
    .synced (pins_s)
  );

  assign sel_s  = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s   = pins_s[0];

  // ==========================================================================
  // Status registers
  // ==========================================================================
  // Faults are reported as ones, healthy as zeros
  assign line_cond = {peak_level, 1'b0, positive_clamp_flag,
                      negative_clamp_flag, kline_overtemp_flag};
  // SPI error pulse replaces bit 3 of the system conditions
  assign sys_cond  = {sys_fault_cond[7:4], q.err,
                      sys_fault_cond[2:0]};

  assign self_test = q.ctl[SSP_ADDR_SELFTEST][SSP_SELFTEST_BIT];

  ssp_status_reg #(
    .EXIST (SSP_LINE_EXIST),
    .FAULT (SSP_LINE_FAULT)
  ) u_line_stat (
    .clk       (clk),
    .reset     (reset),
    .cond      (line_cond),
    .wr_en     (q.wr_line),
    .wr_data   (q.wdata),
    .self_test (self_test),
    .value     (line_conditioner_fault_status)
  );

  ssp_status_reg #(
    .EXIST (SSP_SYS_EXIST),
    .FAULT (SSP_SYS_FAULT)
  ) u_sys_stat (
    .clk       (clk),
    .reset     (reset),
    .cond      (sys_cond),
    .wr_en     (q.wr_sys),
    .wr_data   (q.wdata),
    .self_test (self_test),
    .value     (sys_fault_status)
  );

  // Identity register has no storage, so writes cannot reach it
  assign model_revision_id = {SSP_MODEL_CODE, SSP_REVISION};

  // ==========================================================================
  // Frame engine
  // ==========================================================================
  // Edges come from the second synchroniser stage and a delayed copy.
  // Host keeps select changes away from a high serial clock, so no
  // clock edge is seen in the same sample as a select edge.
  always_comb begin
    ssp_cmd_word_t cw;
    logic          sclk_rise;
    logic          sclk_fall;
    logic          sel_fall;
    logic          sel_rise;
    logic [7:0]    stat_rd;
    logic          stat_ok;

    d          = q;
    cw         = q.rx;
    d.err      = 1'b0;
    d.wr_line  = 1'b0;
    d.wr_sys   = 1'b0;
    sclk_rise  = sclk_s & ~q.sclk_prev;
    sclk_fall  = ~sclk_s & q.sclk_prev;
    sel_fall   = ~sel_s & q.sel_prev;
    sel_rise   = sel_s & ~q.sel_prev;
    d.sclk_prev = sclk_s;
    d.sel_prev  = sel_s;

    // Status read mux, only three status addresses exist
    stat_rd = 8'h00;
    stat_ok = 1'b1;
    case (cw.addr)
      SSP_ADDR_LINE_STAT: begin
        stat_rd = line_conditioner_fault_status;
      end
      SSP_ADDR_SYS_STAT: begin
        stat_rd = sys_fault_status;
      end
      SSP_ADDR_MODEL_REV: begin
        stat_rd = model_revision_id;
      end
      default: begin
        stat_rd = 8'h00;
        stat_ok = 1'b0;
      end
    endcase

    case (q.st)
      SSP_IDLE: begin
        // Clock and data are not looked at while deselected
        if (sel_fall) begin
          d.st    = SSP_FRAME;
          d.cnt   = 5'h00;
          d.tx    = q.resp;
          d.so    = q.resp[SSP_FRAME_BITS-1];
          d.so_oe = 1'b1;
        end
      end
      SSP_FRAME: begin
        if (sel_rise) begin
          d.st    = SSP_IDLE;
          d.so_oe = 1'b0;
          d.so    = 1'b0;
          if (q.cnt != SSP_FRAME_COUNT) begin
            d.err = 1'b1;
          end else begin
            // Execute the received word
            case (cw.cmd)
              SSP_CMD_CHECK: begin
                d.resp = {1'b0, ~q.rx[14:12], q.rx[11:0]};
              end
              SSP_CMD_RD_CFG: begin
                d.resp = {q.rx[15:8], q.cfg[cw.addr]};
              end
              SSP_CMD_WR_CFG: begin
                d.cfg[cw.addr] = cw.data;
                d.resp         = q.rx;
              end
              SSP_CMD_RD_STAT: begin
                if (stat_ok) begin
                  d.resp = {q.rx[15:8], stat_rd};
                end else begin
                  d.err = 1'b1;
                end
              end
              SSP_CMD_WR_STAT: begin
                if (stat_ok) begin
                  d.wdata   = cw.data;
                  d.wr_line = (cw.addr == SSP_ADDR_LINE_STAT);
                  d.wr_sys  = (cw.addr == SSP_ADDR_SYS_STAT);
                  d.resp    = q.rx;
                end else begin
                  d.err = 1'b1;
                end
              end
              SSP_CMD_RD_CTL: begin
                d.resp = {q.rx[15:8], q.ctl[cw.addr]};
              end
              SSP_CMD_WR_CTL: begin
                d.ctl[cw.addr] = cw.data;
                d.resp         = q.rx;
              end
              SSP_CMD_CHK_RESP: begin
                d.resp = q.rx;
              end
              default: begin
                d.err = 1'b1;
              end
            endcase
          end
        end else begin
          // Sample on rise, most significant bit enters first
          if (sclk_rise) begin
            d.rx = {q.rx[14:0], si_s};
            if (q.cnt != SSP_COUNT_MAX) begin
              d.cnt = q.cnt + 5'h01;
            end
          end
          // Shift on fall, so the host sees a settled bit on rise
          if (sclk_fall) begin
            d.tx = {q.tx[14:0], 1'b0};
            d.so = q.tx[14];
          end
        end
      end
      default: begin
        d.st = SSP_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q           <= '0;
      q.st        <= SSP_IDLE;
      q.resp      <= SSP_RESP_RST;
      q.sclk_prev <= 1'b0;
      q.sel_prev  <= 1'b1;
      q.cfg       <= {16{SSP_CFG_RST}};
      q.ctl       <= {16{SSP_CTL_RST}};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // All of these are flip-flop outputs
  assign serial_out             = q.so;
  assign serial_out_oe          = q.so_oe;
  assign self_test_write_enable = self_test;

endmodule

// ===== ssp_pkg.sv
/*
  Shared constants and types of the SPI slave status port.
  Assumes the includers import the whole package.
*/
package ssp_pkg;

  // ==========================================================================
  // Frame and command word
  // ==========================================================================
  localparam int unsigned SSP_FRAME_BITS  = 16;
  localparam logic [4:0]  SSP_FRAME_COUNT = 5'h10;
  localparam logic [4:0]  SSP_COUNT_MAX   = 5'h1f;
  // Fastest serial clock the host may use, in kHz
  localparam int unsigned SSP_SCLK_MAX_KHZ = 8000;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [7:0] data;
  } ssp_cmd_word_t;

  // Command codes
  localparam logic [3:0] SSP_CMD_CHECK     = 4'h0;
  localparam logic [3:0] SSP_CMD_RD_CFG    = 4'h1;
  localparam logic [3:0] SSP_CMD_WR_CFG    = 4'h2;
  localparam logic [3:0] SSP_CMD_RD_STAT   = 4'h3;
  localparam logic [3:0] SSP_CMD_WR_STAT   = 4'h4;
  localparam logic [3:0] SSP_CMD_RD_CTL    = 4'h5;
  localparam logic [3:0] SSP_CMD_WR_CTL    = 4'h6;
  localparam logic [3:0] SSP_CMD_CHK_RESP  = 4'h7;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] SSP_ADDR_LINE_STAT = 4'hb;
  localparam logic [3:0] SSP_ADDR_SYS_STAT  = 4'hd;
  localparam logic [3:0] SSP_ADDR_MODEL_REV = 4'hf;
  localparam logic [3:0] SSP_ADDR_SELFTEST  = 4'he;
  localparam int unsigned SSP_SELFTEST_BIT  = 0;

  // Existing and fault bits of the status registers
  localparam logic [7:0] SSP_LINE_EXIST = 8'hf7;
  localparam logic [7:0] SSP_LINE_FAULT = 8'h07;
  localparam logic [7:0] SSP_SYS_EXIST  = 8'hff;
  localparam logic [7:0] SSP_SYS_FAULT  = 8'h8f;
  localparam int unsigned SSP_SPI_ERR_BIT = 3;

  // Reset values
  localparam logic [7:0]  SSP_STAT_RST = 8'h00;
  localparam logic [7:0]  SSP_CFG_RST  = 8'h00;
  localparam logic [7:0]  SSP_CTL_RST  = 8'h00;
  localparam logic [15:0] SSP_RESP_RST = 16'h0000;

  // Identity codes, values arbitrary
  localparam logic [2:0] SSP_MODEL_CODE = 3'h5;
  localparam logic [4:0] SSP_REVISION   = 5'h03;

  // ==========================================================================
  // Port state
  // ==========================================================================
  typedef enum logic {SSP_IDLE, SSP_FRAME} ssp_state_t;

  typedef struct packed {
    ssp_state_t      st;
    logic [15:0]     rx;
    logic [15:0]     tx;
    logic [4:0]      cnt;
    logic [15:0]     resp;
    logic            so;
    logic            so_oe;
    logic            sclk_prev;
    logic            sel_prev;
    logic            err;
    logic            wr_line;
    logic            wr_sys;
    logic [7:0]      wdata;
    logic [15:0][7:0] cfg;
    logic [15:0][7:0] ctl;
  } ssp_port_s_t;

endpackage

// ===== ssp_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk; only stage two is read.
*/
`timescale 1ns/1ps
module ssp_sync #(
  parameter int unsigned W         = 3,
  parameter logic [W-1:0] RST_VAL  = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Pins and their synchronised copies
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssp_sync_s_t;

  ssp_sync_s_t q;
  ssp_sync_s_t d;

  // ==========================================================================
  // Stages
  // ==========================================================================
  // First stage feeds only the second one
  always_comb begin
    d    = q;
    d.s1 = pins;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign synced = q.s2;

endmodule

// ===== ssp_status_reg.sv
/*
  One 8-bit status register with fault, condition and host write handling.
  Assumes cond and the write strobe come from logic on clk.
*/
`timescale 1ns/1ps
module ssp_status_reg
  import ssp_pkg::*;
#(
  parameter logic [7:0] EXIST = 8'hff,
  parameter logic [7:0] FAULT = 8'hff
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Device conditions and fault events
  input  wire logic [7:0] cond,
  // Host write
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       self_test,
  // Register value
  output logic      [7:0] value
);

  typedef struct packed {
    logic [7:0] val;
  } ssp_stat_s_t;

  ssp_stat_s_t q;
  ssp_stat_s_t d;
  logic [7:0]  base;

  // ==========================================================================
  // Next value
  // ==========================================================================
  // Outside self-test, a fault event in the same cycle as a clearing write wins; in self-test the write wins
  always_comb begin
    d    = q;
    base = wr_en ? (q.val & wr_data) : q.val;
    if (self_test) begin
      d.val = wr_en ? wr_data : q.val;
    end else begin
      d.val = ((base | cond) & FAULT) | (cond & ~FAULT);
    end
    d.val = d.val & EXIST;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{val: SSP_STAT_RST};
    end else begin
      q <= d;
    end
  end

  assign value = q.val;

endmodule

// ===== ssp_port_monitor.sv
/*
  Concurrent checks on the pins and register views of the port.
  Assumes it is bound into ssp_port and that everything runs on clk.
*/
`timescale 1ns/1ps
module ssp_port_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Serial pins
  input wire logic       select_n,
  input wire logic       sclk,
  input wire logic       serial_out,
  input wire logic       serial_out_oe,
  // Conditions
  input wire logic [3:0] peak_level,
  input wire logic       kline_overtemp_flag,
  // Register views
  input wire logic       self_test_write_enable,
  input wire logic [7:0] line_conditioner_fault_status,
  input wire logic [7:0] sys_fault_status
);
  // ==========================================================================
  // Checks
  // ==========================================================================
  // Pin synchronisers add cycles, so windows allow a few of them
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_oe_idle_off: assert property (select_n [*8] |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_oe_frame_on: assert property ($fell(select_n) |-> ##[2:8] serial_out_oe)
    else $error("output not enabled after select");
  a_so_on_fall: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
    |-> !sclk && !$past(sclk, 2))
    else $error("output changed away from a falling clock");
  a_exec_at_rise: assert property ($changed(self_test_write_enable)
    |-> select_n && $past(select_n, 3))
    else $error("control changed outside execution");
  a_err_at_rise: assert property ($changed(sys_fault_status[3])
    |-> select_n && $past(select_n, 3))
    else $error("error bit moved outside execution");
  a_gap_bit_zero: assert property (!line_conditioner_fault_status[3])
    else $error("nonexistent bit set");
  a_ovt_sets: assert property (kline_overtemp_flag && !self_test_write_enable
    |-> ##[1:3] line_conditioner_fault_status[0])
    else $error("overtemp not reported");
  a_ovt_cause: assert property ($rose(line_conditioner_fault_status[0]) && !self_test_write_enable
    |-> $past(kline_overtemp_flag) || $past(kline_overtemp_flag, 2)
        || $past(kline_overtemp_flag, 3))
    else $error("overtemp set without cause");
  a_peak_live: assert property ((!self_test_write_enable && $stable(peak_level)) [*4]
    |-> line_conditioner_fault_status[7:4] == peak_level)
    else $error("peak bits do not follow level");
endmodule

// ===== ssp_host_model.sv
/*
  Host master model: frames 16-bit words, samples the reply on rising clock.
  Assumes the bench calls frame() from one process at a time.
*/
`timescale 1ns/1ps
module ssp_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      select_n,
  output logic      sclk,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  // 13 cycles a half: 130 ns period stays under the 8 MHz ceiling, 50 % duty
  localparam int HALF = 13;
  logic busy = 1'b0;
  logic so_w;

  initial begin
    select_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end
  // A released output reads unknown, so a bit taken outside the enable fails
  assign so_w = serial_out_oe ? serial_out : 1'bx;
  // Data line wanders between frames; a port listening while idle goes wrong
  always @(posedge clk) if (!busy) serial_in <= ~serial_in;

  // One frame of np pulses; select moves only with the clock low
  task automatic frame(input logic [15:0] w, input int np, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    busy = 1'b1;
    @(posedge clk);
    select_n <= 1'b0;
    serial_in <= w[15];
    for (i = 0; i < np; i++) begin
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      rx = {rx[14:0], so_w};
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
      serial_in <= w[15 - ((i + 1) % 16)];
    end
    repeat (HALF) @(posedge clk);
    select_n <= 1'b1;
    repeat (2 * HALF) @(posedge clk);
    busy = 1'b0;
  endtask
endmodule

// ===== tb_ssp_port.sv
/*
  Self-checking bench of the port: frames, errors, status and identity.
  Assumes ssp_host_model drives the pins and the monitor is bound below.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_ssp_port;
  import ssp_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        select_n, sclk, serial_in, serial_out, serial_out_oe;
  logic [3:0]  peak_level = 4'h0;
  logic [2:0]  flt = 3'h0;
  logic [7:0]  sys_fault_cond = 8'h08;
  logic        st_en;
  logic [7:0]  line_st, sys_st;
  logic [15:0] exp_rsp = SSP_RESP_RST;
  logic [15:0] rx;
  logic [15:0] bad [4] = '{16'h0123, 16'h0123, 16'h8123, 16'h3a00};
  int          np [4] = '{15, 17, 16, 16};
  int          n_fail = 0;
  int          cmp_count = 0;

  always #2.5 clk = ~clk;

  ssp_host_model host (.clk(clk), .select_n(select_n), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  ssp_port dut (.clk(clk), .reset(reset), .select_n(select_n), .sclk(sclk),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .peak_level(peak_level), .positive_clamp_flag(flt[2]), .negative_clamp_flag(flt[1]),
    .kline_overtemp_flag(flt[0]), .sys_fault_cond(sys_fault_cond),
    .self_test_write_enable(st_en), .line_conditioner_fault_status(line_st),
    .sys_fault_status(sys_st));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Reply owed to word w, given the read data d it fetches
  function automatic logic [15:0] f_resp(logic [15:0] w, logic [7:0] d);
    case (w[15:12])
      4'h0: return {1'b0, ~w[14:12], w[11:0]};
      4'h1, 4'h3, 4'h5: return {w[15:8], d};
      default: return w;
    endcase
  endfunction

  // Refused frames (ok clear) leave the owed reply untouched
  task automatic xfer(input logic [15:0] w, input int n, input logic [7:0] d, input bit ok);
    host.frame(w, n, rx);
    if (n == 16) `CHK(rx, exp_rsp)
    if (ok) exp_rsp = f_resp(w, d);
  endtask

  task automatic fault(input logic [2:0] f);
    @(posedge clk) flt <= f;
    @(posedge clk) flt <= 3'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    int i;
    logic [15:0] w;
    logic [3:0] a, pk;
    logic [7:0] d;
    void'($urandom(32'h91c4));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    sys_fault_cond <= 8'($urandom()) | 8'h08;
    repeat (5) @(posedge clk);
    `CHK(line_st, 8'h00)
    `CHK(sys_st, sys_fault_cond & ~(8'h01 << SSP_SPI_ERR_BIT))
    `CHK(st_en, 1'b0)
    `CHK(serial_out_oe, 1'b0)
    $display("reset done");
    xfer(16'h0abc, 16, 8'h00, 1);
    xfer(16'h0fff, 16, 8'h00, 1);
    for (i = 0; i < 8; i++) xfer({4'h0, 12'($urandom())}, 16, 8'h00, 1);
    $display("check done");
    for (i = 0; i < 6; i++) begin
      a = 4'($urandom());
      if (a == SSP_ADDR_SELFTEST) a = 4'h0;
      d = 8'($urandom());
      w = {(i < 3) ? SSP_CMD_WR_CFG : SSP_CMD_WR_CTL, a, d};
      xfer(w, 16, 8'h00, 1);
      xfer({w[15:12] - 4'h1, a, 8'h00}, 16, d, 1);
    end
    xfer(16'h7123, 16, 8'h00, 1);
    $display("config done");
    for (i = 0; i < 4; i++) begin
      xfer(bad[i], np[i], 8'h00, 0);
      `CHK(sys_st[SSP_SPI_ERR_BIT], 1'b1)
      xfer(16'h4d00, 16, 8'h00, 1);
      `CHK(sys_st[SSP_SPI_ERR_BIT], 1'b0)
    end
    $display("errors done");
    pk = 4'($urandom());
    peak_level <= pk;
    fault(3'b001);
    `CHK(line_st, {pk, 4'h1})
    xfer(16'h3b00, 16, {pk, 4'h1}, 1);
    xfer(16'h4bff, 16, 8'h00, 1);
    `CHK(line_st, {pk, 4'h1})
    xfer(16'h4b00, 16, 8'h00, 1);
    `CHK(line_st, {pk, 4'h0})
    fault(3'b110);
    `CHK(line_st, {pk, 4'h6})
    xfer(16'h6e01, 16, 8'h00, 1);
    `CHK(st_en, 1'b1)
    xfer(16'h4bff, 16, 8'h00, 1);
    `CHK(line_st, 8'hf7)
    xfer(16'h4b00, 16, 8'h00, 1);
    fault(3'b111);
    peak_level <= ~pk;
    `CHK(line_st, 8'h00)
    xfer(16'h6e00, 16, 8'h00, 1);
    `CHK(line_st, {~pk, 4'h0})
    $display("status done");
    xfer(16'h3f00, 16, {SSP_MODEL_CODE, SSP_REVISION}, 1);
    xfer(16'h4fff, 16, 8'h00, 1);
    xfer(16'h3f00, 16, {SSP_MODEL_CODE, SSP_REVISION}, 1);
    xfer(16'h0000, 16, 8'h00, 1);
    $display("ident done");
    close_out;
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("Error %0t: timeout", $time);
    close_out;
  end
endmodule

bind ssp_port ssp_port_monitor mon (.clk(clk), .reset(reset), .select_n(select_n),
  .sclk(sclk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .peak_level(peak_level), .kline_overtemp_flag(kline_overtemp_flag),
  .self_test_write_enable(self_test_write_enable),
  .line_conditioner_fault_status(line_conditioner_fault_status),
  .sys_fault_status(sys_fault_status));
